// File: logic/ssc_pkg.sv
// constants and types shared by the serial clock and mode configuration block
package ssc_pkg;

  // ---------------------------------------------------------------
  // register indices and byte addresses (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [13:0] SSC_CLK0_IDX    = 14'h1fb5;
  localparam logic [13:0] SSC_CLK1_IDX    = 14'h1fb7;
  localparam logic [13:0] SSC_STAT_IDX    = 14'h1fb8;
  localparam int          SSC_ADDR_W      = 16;
  localparam logic [15:0] SSC_CLK0_ADDR   = {SSC_CLK0_IDX, 2'b00};
  localparam logic [15:0] SSC_CLK1_ADDR   = {SSC_CLK1_IDX, 2'b00};
  localparam logic [15:0] SSC_STAT_ADDR   = {SSC_STAT_IDX, 2'b00};

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int          SSC_POL_BIT     = 0;
  localparam int          SSC_PHA_BIT     = 1;
  localparam int          SSC_PND_BIT     = 2;
  localparam int          SSC_IEN_BIT     = 3;
  localparam int          SSC_DUP_BIT     = 4;
  localparam int          SSC_CHS_BIT     = 5;
  localparam logic [7:0]  SSC_CLK0_MASK   = 8'h03;
  localparam logic [7:0]  SSC_CLK1_MASK   = 8'h3f;
  localparam logic [7:0]  SSC_CLK0_RST    = 8'h00;
  localparam logic [7:0]  SSC_CLK1_RST    = 8'h00;
  localparam int          SSC_ST_SC0_BIT  = 0;
  localparam int          SSC_ST_SC1_BIT  = 1;
  localparam int          SSC_ST_REQ_BIT  = 2;

  // ---------------------------------------------------------------
  // operating modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SSC_MODE_STD,
    SSC_MODE_DUPLEX,
    SSC_MODE_CHSEL
  } ssc_mode_e;

endpackage

// File: logic/ssc_sync2.sv
// two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ns
module ssc_sync2
  import ssc_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_ff;
  logic sync_ff;

  // the first stage feeds the second stage and nothing else
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else if (ce_i) begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

// File: logic/ssc_edge_sel.sv
// picks shift and sample edges of one serial clock from its idle level and phase
`timescale 1ns/1ns
module ssc_edge_sel
  import ssc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic sclk_i,
  input  wire logic idle_high_i,
  input  wire logic late_phase_i,
  output logic      shift_o,
  output logic      sample_o
);

  logic prev_ff;
  logic shift_ff;
  logic sample_ff;
  logic rise;
  logic fall;
  logic leading;
  logic trailing;
  logic nxt_shift;
  logic nxt_sample;

  assign rise     = sclk_i & ~prev_ff;
  assign fall     = ~sclk_i & prev_ff;
  // leading edge leaves the idle level, trailing edge returns to it
  assign leading  = idle_high_i ? fall : rise;
  assign trailing = idle_high_i ? rise : fall;
  // early phase samples on leading and shifts on trailing; late phase swaps
  assign nxt_sample = late_phase_i ? trailing : leading;
  assign nxt_shift  = late_phase_i ? leading : trailing;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_ff   <= 1'b0;
      shift_ff  <= 1'b0;
      sample_ff <= 1'b0;
    end else if (ce_i) begin
      prev_ff   <= sclk_i;
      shift_ff  <= nxt_shift;
      sample_ff <= nxt_sample;
    end
  end

  assign shift_o  = shift_ff;
  assign sample_o = sample_ff;

endmodule

// File: logic/ssc_clock_mode.sv
// serial clock shape and mode configuration with apb register access
//
// Summary of operation
// [RL1] standard mode clocks channel 0 alone from the first clock line, shaped by register 0.
// [RL2] duplex and channel-select modes clock both channels from the first clock line.
// [RL3] standard mode clocks channel 1 from the second line, shaped by register 1.
// [RL4] register 0 resets to zero and holds idle level in bit 0 and edge timing in bit 1.
// [RL5] idle level select 0 means the clock idles low, 1 means it idles high.
// [RL6] idle level and edge timing choose the edge on which transmit bits shift out.
// [RL7] idle level and edge timing choose the edge on which receive bits are sampled.
// [RL8] register 1 resets to zero and its bits 5 and 4 choose the operating mode.
// [RL9] register 1 holds an enable for the contention interrupt in channel-select master use.
// [RL10] software writes zeros to the unused upper bits of both registers.
// [RL11] an external channel request in channel-select master use sets the pending flag
// [RL12] edge timing picks leading or trailing edge, and handshake transfers ignore the shape.
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
module ssc_clock_mode
  import ssc_pkg::*;
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_N_I,
  input  wire logic        CE_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [15:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // serial clock lines and channel request pin, asynchronous
  input  wire logic        SHARED_SERIAL_CLOCK_LINE_I,
  input  wire logic        SECOND_SERIAL_CLOCK_LINE_I,
  input  wire logic        CHANNEL_REQUEST_PIN_N_I,
  // from the handshake control and shifter, same clock
  input  wire logic        CH0_HANDSHAKE_I,
  input  wire logic        CH1_HANDSHAKE_I,
  input  wire logic        CHSEL_MASTER_I,
  // to the shifter and the clock drivers
  output logic             CH0_IDLE_HIGH_O,
  output logic             CH1_IDLE_HIGH_O,
  output logic             CH0_SHIFT_O,
  output logic             CH0_SAMPLE_O,
  output logic             CH1_SHIFT_O,
  output logic             CH1_SAMPLE_O,
  output logic             CH1_ON_SHARED_O,
  output logic             DUPLEX_MODE_O,
  output logic             CHSEL_MODE_O,
  output logic             CONTENTION_PENDING_O,
  output logic             CH0_IRQ_SET_O
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  clk0_shape_ff;
  logic [7:0]  clk1_mode_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        ch0_idle_ff;
  logic        ch1_idle_ff;
  logic        ch1_shared_ff;
  logic        dup_mode_ff;
  logic        chs_mode_ff;
  logic        irq_set_ff;
  logic        req_prev_ff;

  logic [7:0]  nxt_clk0_shape;
  logic [7:0]  nxt_clk1_mode;
  logic [31:0] nxt_prdata;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic sc0_sync;
  logic sc1_sync;
  logic req_n_sync;

  ssc_sync2 #(.RST_VAL(1'b0)) u_sync_sc0 (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RESET_N_I),
    .ce_i    (CE_I),
    .async_i (SHARED_SERIAL_CLOCK_LINE_I),
    .sync_o  (sc0_sync)
  );

  ssc_sync2 #(.RST_VAL(1'b0)) u_sync_sc1 (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RESET_N_I),
    .ce_i    (CE_I),
    .async_i (SECOND_SERIAL_CLOCK_LINE_I),
    .sync_o  (sc1_sync)
  );

  // pin idles high, so the synchroniser starts high to avoid a false request
  ssc_sync2 #(.RST_VAL(1'b1)) u_sync_req (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RESET_N_I),
    .ce_i    (CE_I),
    .async_i (CHANNEL_REQUEST_PIN_N_I),
    .sync_o  (req_n_sync)
  );

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  logic      pol0;
  logic      pha0;
  logic      pol1;
  logic      pha1;
  logic      contention_irq_enable;
  logic      contention_pending_flag;
  ssc_mode_e mode;

  assign pol0   = clk0_shape_ff[SSC_POL_BIT]; // RL4
  assign pha0   = clk0_shape_ff[SSC_PHA_BIT]; // RL4
  assign pol1   = clk1_mode_ff[SSC_POL_BIT];
  assign pha1   = clk1_mode_ff[SSC_PHA_BIT];
  assign contention_irq_enable = clk1_mode_ff[SSC_IEN_BIT]; // RL9
  assign contention_pending_flag = clk1_mode_ff[SSC_PND_BIT];

  // both mode codes with the high bit set run channel-select
  assign mode = clk1_mode_ff[SSC_CHS_BIT] ? SSC_MODE_CHSEL :
                clk1_mode_ff[SSC_DUP_BIT] ? SSC_MODE_DUPLEX :
                SSC_MODE_STD; // RL8

  // ---------------------------------------------------------------
  // clock routing and shape per channel
  // ---------------------------------------------------------------
  logic ch1_shared;
  logic ch1_sclk;
  logic ch1_pol;
  logic ch1_pha;
  logic ch0_idle_eff;
  logic ch0_pha_eff;
  logic ch1_idle_eff;
  logic ch1_pha_eff;

  logic nxt_ch1_shared;
  logic nxt_dup_mode;
  logic nxt_chs_mode;

  always_comb begin
    nxt_ch1_shared = 1'b0;
    nxt_dup_mode   = 1'b0;
    nxt_chs_mode   = 1'b0;
    case (mode)
      SSC_MODE_STD: begin
        nxt_ch1_shared = 1'b0; // RL1 RL3
      end
      SSC_MODE_DUPLEX: begin
        nxt_ch1_shared = 1'b1; // RL2
        nxt_dup_mode   = 1'b1;
      end
      SSC_MODE_CHSEL: begin
        nxt_ch1_shared = 1'b1; // RL2
        nxt_chs_mode   = 1'b1;
      end
      default: begin
        nxt_ch1_shared = 1'b0;
      end
    endcase
  end

  assign ch1_shared = nxt_ch1_shared;
  // channel 1 follows the first line and register 0 outside standard mode
  assign ch1_sclk = ch1_shared ? sc0_sync : sc1_sync; // RL2 RL3
  assign ch1_pol  = ch1_shared ? pol0 : pol1; // RL3
  assign ch1_pha  = ch1_shared ? pha0 : pha1; // RL3

  // handshake transfers run a fixed idle-low, early-phase shape
  assign ch0_idle_eff = CH0_HANDSHAKE_I ? 1'b0 : pol0; // RL5 RL12
  assign ch0_pha_eff  = CH0_HANDSHAKE_I ? 1'b0 : pha0; // RL12
  assign ch1_idle_eff = CH1_HANDSHAKE_I ? 1'b0 : ch1_pol; // RL5 RL12
  assign ch1_pha_eff  = CH1_HANDSHAKE_I ? 1'b0 : ch1_pha; // RL12

  // channel 0 always uses the first line, and register 0 outside handshake transfers
  ssc_edge_sel u_edge_ch0 (
    .clk_i        (CLK_SYS_I),
    .rst_n_i      (RESET_N_I),
    .ce_i         (CE_I),
    .sclk_i       (sc0_sync),
    .idle_high_i  (ch0_idle_eff),
    .late_phase_i (ch0_pha_eff),
    .shift_o      (CH0_SHIFT_O),
    .sample_o     (CH0_SAMPLE_O)
  ); // RL1 RL6 RL7

  ssc_edge_sel u_edge_ch1 (
    .clk_i        (CLK_SYS_I),
    .rst_n_i      (RESET_N_I),
    .ce_i         (CE_I),
    .sclk_i       (ch1_sclk),
    .idle_high_i  (ch1_idle_eff),
    .late_phase_i (ch1_pha_eff),
    .shift_o      (CH1_SHIFT_O),
    .sample_o     (CH1_SAMPLE_O)
  ); // RL6 RL7

  // ---------------------------------------------------------------
  // master contention detection
  // ---------------------------------------------------------------
  logic req_assert;
  logic cont_set;

  // request pin is active low: assertion is a high-to-low change
  assign req_assert = req_prev_ff & ~req_n_sync;
  assign cont_set   = req_assert & chs_mode_ff & CHSEL_MASTER_I; // RL11

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic setup;
  logic access;
  logic hit_clk0;
  logic hit_clk1;
  logic hit_stat;
  logic hit_any;
  logic wr_clk0;
  logic wr_clk1;
  logic [7:0] wbyte;
  logic [7:0] stat_val;

  assign setup    = PSEL_I & ~PENABLE_I;
  // writes land on the edge where pready is seen high
  assign access   = PSEL_I & PENABLE_I & pready_ff;
  assign hit_clk0 = (PADDR_I == SSC_CLK0_ADDR);
  assign hit_clk1 = (PADDR_I == SSC_CLK1_ADDR);
  assign hit_stat = (PADDR_I == SSC_STAT_ADDR);
  assign hit_any  = hit_clk0 | hit_clk1 | hit_stat;
  assign wr_clk0  = access & PWRITE_I & hit_clk0;
  assign wr_clk1  = access & PWRITE_I & hit_clk1;
  assign wbyte    = PWDATA_I[7:0];

  assign stat_val = {5'h00, ~req_n_sync, sc1_sync, sc0_sync};

  // upper bits are not stored, so stray ones written there read back zero
  assign nxt_clk0_shape = wr_clk0 ? (wbyte & SSC_CLK0_MASK) : clk0_shape_ff; // RL4 RL10

  // pending flag: write 0 clears, write 1 keeps; a new contention wins over a clear
  logic nxt_pnd;
  assign nxt_pnd = cont_set | (contention_pending_flag & ~(wr_clk1 & ~wbyte[SSC_PND_BIT])); // RL11

  logic [7:0] clk1_wr_val;
  assign clk1_wr_val   = wbyte & SSC_CLK1_MASK; // RL10
  assign nxt_clk1_mode = wr_clk1 ?
                         {clk1_wr_val[7:3], nxt_pnd, clk1_wr_val[1:0]} :
                         {clk1_mode_ff[7:3], nxt_pnd, clk1_mode_ff[1:0]}; // RL8 RL9

  assign nxt_prdata = hit_clk0 ? {24'h000000, clk0_shape_ff} :
                      hit_clk1 ? {24'h000000, clk1_mode_ff} :
                      hit_stat ? {24'h000000, stat_val} :
                      32'h00000000;

  // ---------------------------------------------------------------
  // sequential state
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      clk0_shape_ff <= SSC_CLK0_RST; // RL4
      clk1_mode_ff  <= SSC_CLK1_RST; // RL8
    end else if (CE_I) begin
      clk0_shape_ff <= nxt_clk0_shape;
      clk1_mode_ff  <= nxt_clk1_mode;
    end
  end

  // ---------------------------------------------------------------
  // apb response
  // ---------------------------------------------------------------
  // one wait-free access cycle: pready rises on the edge that ends setup
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else if (CE_I) begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~hit_any;
      if (setup) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // channel shape and mode state
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      ch0_idle_ff <= 1'b0;
      ch1_idle_ff <= 1'b0;
    end else if (CE_I) begin
      ch0_idle_ff <= ch0_idle_eff; // RL5
      ch1_idle_ff <= ch1_idle_eff; // RL5
    end
  end

  // mode levels lag the register by one cycle, so contention gating
  // follows a mode write one cycle late
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      ch1_shared_ff <= 1'b0;
      dup_mode_ff   <= 1'b0;
      chs_mode_ff   <= 1'b0;
    end else if (CE_I) begin
      ch1_shared_ff <= ch1_shared;
      dup_mode_ff   <= nxt_dup_mode;
      chs_mode_ff   <= nxt_chs_mode;
    end
  end

  // ---------------------------------------------------------------
  // contention state
  // ---------------------------------------------------------------
  // request history starts released, so leaving reset cannot fake an assertion
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      irq_set_ff  <= 1'b0;
      req_prev_ff <= 1'b1;
    end else if (CE_I) begin
      irq_set_ff  <= cont_set & contention_irq_enable; // RL11
      req_prev_ff <= req_n_sync;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign PRDATA_O             = prdata_ff;
  assign PREADY_O             = pready_ff;
  assign PSLVERR_O            = pslverr_ff;
  assign CH0_IDLE_HIGH_O      = ch0_idle_ff;
  assign CH1_IDLE_HIGH_O      = ch1_idle_ff;
  assign CH1_ON_SHARED_O      = ch1_shared_ff;
  assign DUPLEX_MODE_O        = dup_mode_ff;
  assign CHSEL_MODE_O         = chs_mode_ff;
  assign CONTENTION_PENDING_O = clk1_mode_ff[SSC_PND_BIT];
  assign CH0_IRQ_SET_O        = irq_set_ff;

endmodule

// File: sim/ssc_clock_mode_chk.sv
// concurrent checks on the ports of the serial clock and mode block
`timescale 1ns/1ns
module ssc_clock_mode_chk
  import ssc_pkg::*;
(
  input wire logic        CLK_SYS_I,
  input wire logic        RESET_N_I,
  input wire logic        CE_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        SHARED_SERIAL_CLOCK_LINE_I,
  input wire logic        CH0_HANDSHAKE_I,
  input wire logic        CH0_IDLE_HIGH_O,
  input wire logic        CH0_SHIFT_O,
  input wire logic        CH0_SAMPLE_O,
  input wire logic        CH1_ON_SHARED_O,
  input wire logic        DUPLEX_MODE_O,
  input wire logic        CHSEL_MODE_O,
  input wire logic        CONTENTION_PENDING_O,
  input wire logic        CH0_IRQ_SET_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  sequence acc0_s;
    PSEL_I && PENABLE_I && PREADY_O && PADDR_I == SSC_CLK0_ADDR;
  endsequence
  property idle_p;
    logic v;
    (acc0_s ##0 (PWRITE_I && !CH0_HANDSHAKE_I, v = PWDATA_I[0])) |->
      ##[1:2] (CH0_IDLE_HIGH_O == v);
  endproperty
  pready_one_a: assert property (PSEL_I && !PENABLE_I && CE_I |=> PREADY_O ##1 !PREADY_O)
    else $error("ready not a single cycle after setup");
  slverr_ready_a: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error flag without ready");
  rdata_upper_a: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h0)
    else $error("upper read data not zero");
  reg0_unused_a: assert property (acc0_s ##0 !PWRITE_I |-> PRDATA_O[7:2] == 6'h0)
    else $error("unused bits of clock register 0 read nonzero");
  idle_level_a: assert property (idle_p)
    else $error("idle level does not follow written value");

  // ---------------------------------------------------------------
  // serial clock, mode and contention
  // ---------------------------------------------------------------
  edge_pulse_a: assert property ($rose(SHARED_SERIAL_CLOCK_LINE_I) |->
    ##[2:6] (CH0_SAMPLE_O || CH0_SHIFT_O))
    else $error("no channel 0 pulse after a clock edge");
  mode_excl_a: assert property (!(DUPLEX_MODE_O && CHSEL_MODE_O))
    else $error("two modes decoded at once");
  shared_clock_a: assert property (DUPLEX_MODE_O || CHSEL_MODE_O |-> CH1_ON_SHARED_O)
    else $error("channel 1 not on shared line");
  pend_mode_a: assert property ($rose(CONTENTION_PENDING_O) |-> CHSEL_MODE_O)
    else $error("pending set outside channel-select mode");
  irq_pend_a: assert property (CH0_IRQ_SET_O |-> CONTENTION_PENDING_O ##1 !CH0_IRQ_SET_O)
    else $error("interrupt pulse without pending or too long");
endmodule

bind ssc_clock_mode ssc_clock_mode_chk chk_u (
  .CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I), .CE_I(CE_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .SHARED_SERIAL_CLOCK_LINE_I(SHARED_SERIAL_CLOCK_LINE_I),
  .CH0_HANDSHAKE_I(CH0_HANDSHAKE_I), .CH0_IDLE_HIGH_O(CH0_IDLE_HIGH_O),
  .CH0_SHIFT_O(CH0_SHIFT_O), .CH0_SAMPLE_O(CH0_SAMPLE_O),
  .CH1_ON_SHARED_O(CH1_ON_SHARED_O), .DUPLEX_MODE_O(DUPLEX_MODE_O),
  .CHSEL_MODE_O(CHSEL_MODE_O), .CONTENTION_PENDING_O(CONTENTION_PENDING_O),
  .CH0_IRQ_SET_O(CH0_IRQ_SET_O)
);

// File: sim/ssc_serial_peer.sv
// behavioural far side: two serial clock lines and the channel request pin
`timescale 1ns/1ns
module ssc_serial_peer (
  output logic sclk0_o,
  output logic sclk1_o,
  output logic req_n_o
);
  // request pin is pulled up, so it rests high when nobody contends
  initial begin
    sclk0_o = 1'b0;
    sclk1_o = 1'b0;
    req_n_o = 1'b1;
  end
  // lines move a few ns after the system edge so they never race its sampling
  task automatic idle(input logic ln, input logic lvl);
    #3;
    if (ln) sclk1_o = lvl;
    else sclk0_o = lvl;
  endtask
  // clock runs only inside a frame and ends at its idle level
  task automatic frame(input logic ln, input int n);
    #3;
    repeat (2 * n) begin
      if (ln) sclk1_o = !sclk1_o;
      else sclk0_o = !sclk0_o;
      #80;
    end
  endtask
  task automatic contend();
    #3;
    req_n_o = 1'b0;
    #400;
    req_n_o = 1'b1;
    #400;
  endtask
endmodule

// File: sim/tb_ssc_clock_mode.sv
// self-checking bench for the serial clock and mode block
`timescale 1ns/1ns
module tb_ssc_clock_mode
  import ssc_pkg::*;
;
  logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, re;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic        sclk0, sclk1, req_n, hs0, hs1, master, mon, r0, r1, shr;
  logic        idle0, idle1, sh0, sa0, sh1, sa1, on_sh, two_way_mode_bit, mode_high_bit, pnd, irq;
  int          n0, n1, ni, cyc, mismatches, compares;

  ssc_serial_peer peer_u (.sclk0_o(sclk0), .sclk1_o(sclk1), .req_n_o(req_n));
  ssc_clock_mode dut_u (
    .CLK_SYS_I(clk_sys), .RESET_N_I(reset_n), .CE_I(1'b1),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .SHARED_SERIAL_CLOCK_LINE_I(sclk0), .SECOND_SERIAL_CLOCK_LINE_I(sclk1),
    .CHANNEL_REQUEST_PIN_N_I(req_n), .CH0_HANDSHAKE_I(hs0), .CH1_HANDSHAKE_I(hs1),
    .CHSEL_MASTER_I(master), .CH0_IDLE_HIGH_O(idle0), .CH1_IDLE_HIGH_O(idle1),
    .CH0_SHIFT_O(sh0), .CH0_SAMPLE_O(sa0), .CH1_SHIFT_O(sh1), .CH1_SAMPLE_O(sa1),
    .CH1_ON_SHARED_O(on_sh), .DUPLEX_MODE_O(two_way_mode_bit), .CHSEL_MODE_O(mode_high_bit),
    .CONTENTION_PENDING_O(pnd), .CH0_IRQ_SET_O(irq));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // only the bench timeout ends a wait that never sees ready
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // m mode bits, s0 and s1 shapes {phase, idle}, hs handshake on both channels
  task automatic shape(input logic [1:0] m, input logic [1:0] s0, input logic [1:0] s1,
                       input logic hs);
    logic [1:0] e0;
    logic [1:0] e1;
    mon = 1'b0;
    e0 = hs ? 2'b00 : s0;
    shr = (m != 2'b00);
    e1 = hs ? 2'b00 : shr ? s0 : s1;
    r0 = (e0[0] == e0[1]);
    r1 = (e1[0] == e1[1]);
    apb(1'b1, SSC_CLK0_ADDR, {30'h0, s0});
    apb(1'b1, SSC_CLK1_ADDR, {26'h0, m, 2'b00, s1});
    hs0 <= hs;
    hs1 <= hs;
    peer_u.idle(1'b0, e0[0]);
    peer_u.idle(1'b1, e1[0]);
    #800;
    n0 = 0;
    n1 = 0;
    mon = 1'b1;
    chk(idle0, e0[0]);
    chk(idle1, e1[0]);
    chk(on_sh, shr);
    chk(two_way_mode_bit, m == 2'b01);
    chk(mode_high_bit, m[1]);
    peer_u.frame(1'b0, 4);
    if (!shr) peer_u.frame(1'b1, 3);
    #400;
    chk(n0, 4);
    chk(n1, shr ? 4 : 3);
  endtask
  // writing bit 2 as zero also clears a pending flag left from before
  task automatic cont(input logic [7:0] v, input logic ep, input int ei);
    apb(1'b1, SSC_CLK1_ADDR, {24'h0, v});
    ni = 0;
    peer_u.contend();
    chk(pnd, ep);
    chk(ni, ei);
    apb(1'b0, SSC_CLK1_ADDR, 32'h0);
    chk(rq, {24'h0, v | {5'h0, ep, 2'b00}});
  endtask

  // ---------------------------------------------------------------
  // clock, monitor, timeout and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
    if (irq === 1'b1) ni++;
    if (mon && sa0 === 1'b1) begin
      n0++;
      chk(sclk0, r0);
    end
    if (mon && sh0 === 1'b1) chk(sclk0, !r0);
    if (mon && sa1 === 1'b1) begin
      n1++;
      chk(shr ? sclk0 : sclk1, r1);
    end
    if (mon && sh1 === 1'b1) chk(shr ? sclk0 : sclk1, !r1);
  end
  initial begin
    {cyc, n0, n1, ni, mismatches, compares} = '0;
    {reset_n, psel, penable, pwrite, hs0, hs1, master, mon, r0, r1, shr} = '0;
    paddr  = 16'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    apb(1'b0, SSC_CLK0_ADDR, 32'h0);
    chk(rq, 32'h0);
    apb(1'b0, SSC_CLK1_ADDR, 32'h0);
    chk(rq, 32'h0);
    apb(1'b0, 16'h0000, 32'h0);
    chk({rq[30:0], re}, 32'h1);
    apb(1'b1, SSC_CLK0_ADDR, 32'h03);
    apb(1'b0, SSC_CLK0_ADDR, 32'h0);
    chk(rq, 32'h03);
    apb(1'b1, SSC_CLK1_ADDR, 32'h3f);
    apb(1'b0, SSC_CLK1_ADDR, 32'h0);
    chk(rq, 32'h3b);
    for (int i = 0; i < 4; i++) shape(2'b00, i[1:0], ~i[1:0], 1'b0);
    shape(2'b01, 2'b10, 2'b01, 1'b0);
    shape(2'b10, 2'b01, 2'b11, 1'b0);
    shape(2'b11, 2'b11, 2'b00, 1'b0);
    shape(2'b00, 2'b11, 2'b01, 1'b1);
    @(posedge clk_sys);
    hs0    <= 1'b0;
    hs1    <= 1'b0;
    master <= 1'b1;
    cont(8'h28, 1'b1, 1);
    cont(8'h20, 1'b1, 0);
    cont(8'h00, 1'b0, 0);
    master <= 1'b0;
    cont(8'h28, 1'b0, 0);
    results();
  end
endmodule
